// ---- omcp_pkg.sv ----
package omcp_pkg;

   // ***********************************************
   // Rate range encodings
   // ***********************************************
   localparam logic RATE_LOW = 1'b0;
   localparam logic RATE_HIGH = 1'b1;

   // ***********************************************
   // Reset values and pin output-enable levels
   // ***********************************************
   localparam logic RST_LASER_OFF = 1'b1;
   localparam logic RST_RATE = 1'b0;
   localparam logic OE_DRIVE = 1'b0;
   localparam logic OE_RELEASE = 1'b1;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int STABLE_TIME_NS = 100;
   localparam int STABLE_CYCLES = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STABLE_W = $clog2(STABLE_CYCLES + 1);

   // ***********************************************
   // Carrier types
   // ***********************************************
   typedef enum logic [1:0] {
      OMCP_MODE_RATE,
      OMCP_MODE_ALT
   } omcp_sel_mode_e;

   typedef struct packed {
      logic rx_rate_pick;
      logic tx_rate_pick;
   } omcp_pick_s;

   typedef struct packed {
      logic rx_high_rate;
      logic tx_high_rate;
      logic alt_select_zero;
      logic alt_select_one;
   } omcp_rate_s;

   typedef struct packed {
      logic out_bit;
      logic oe_n;
   } omcp_od_s;

endpackage

// ---- omcp_od_pin.sv ----
`timescale 1ns/1ps
`default_nettype none

module omcp_od_pin #(
   parameter bit IMPLEMENTED = 1'b1
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Status to report
   input wire logic i_assert,
   // Pin
   output omcp_pkg::omcp_od_s o_pin
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic oe_n;
   } omcp_od_state_s;

   omcp_od_state_s state_reg;
   omcp_od_state_s state_next;

   // The pin only ever pulls low; a high level comes from the host's pull-up.
   always_comb begin
      state_next = state_reg;
      if (!IMPLEMENTED) begin
         state_next.oe_n = omcp_pkg::OE_DRIVE;
      end else begin
         state_next.oe_n = i_assert ? omcp_pkg::OE_RELEASE : omcp_pkg::OE_DRIVE;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= '{oe_n: omcp_pkg::OE_DRIVE};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_pin.out_bit = 1'b0;
   assign o_pin.oe_n = state_reg.oe_n;

endmodule
`default_nettype wire

// ---- omcp_filter.sv ----
`timescale 1ns/1ps
`default_nettype none

module omcp_filter #(
   parameter int CYCLES = omcp_pkg::STABLE_CYCLES,
   parameter bit RST_VAL = 1'b0
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Level
   input wire logic i_level,
   output logic o_level
);

   // ***********************************************
   // State
   // ***********************************************
   // The counter is sized from this filter's own length, so a longer hold cannot wrap it.
   localparam int CNT_W = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic level;
   } omcp_flt_state_s;

   omcp_flt_state_s state_reg;
   omcp_flt_state_s state_next;

   // A level must hold for a few cycles so that contact bounce on insertion is not acted on.
   always_comb begin
      state_next = state_reg;
      if (i_level == state_reg.level) begin
         state_next.cnt = '0;
      end else if (state_reg.cnt == CNT_W'(CYCLES - 1)) begin
         state_next.cnt = '0;
         state_next.level = i_level;
      end else begin
         state_next.cnt = state_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= '{cnt: '0, level: RST_VAL};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_level = state_reg.level;

endmodule
`default_nettype wire

// ---- omcp_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - The fault status pin reads high whenever the transmitter has detected a laser fault.
// - Without fault detection the fault status pin is held low permanently.
// - The fault status pin is open-drain, only pulled low or released for the host pull-up.
// - The transmitter output is off whenever laser-off is high or unconnected.
// - A passive cable variant may ignore laser-off, while active modules honour it.
// - Laser-off is pulled up internally, so an undriven input disables the transmitter.
// - The transmitter runs normally while laser-off is held low.
// - The receive-rate pick optionally selects the receive path rate range.
// - The transmit-rate pick optionally selects the transmit path rate range.
// - Both rate picks are weakly pulled low, so undriven means low rate.
// - In the alternative scheme the two picks become alternate selects zero and one.
// - A low pick means 4.25 GBd or below and a high pick means above 4.25 GBd.
// - The module-missing contact is tied to ground while the module is inserted.
// - The receive signal lost pin reads high when received optical level is too low.

module omcp_ctrl #(
   parameter bit FAULT_IMPL = 1'b1,
   parameter bit LOS_IMPL = 1'b1,
   parameter bit PASSIVE = 1'b0,
   parameter int STABLE = omcp_pkg::STABLE_CYCLES
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Host contacts: laser-off request with its connection sense
   input wire logic i_laser_off,
   input wire logic i_laser_off_driven,
   // Host contacts: rate picks with their connection sense
   input wire omcp_pkg::omcp_pick_s i_pick,
   input wire omcp_pkg::omcp_pick_s i_pick_driven,
   // Module internal status
   input wire logic i_laser_fault,
   input wire logic i_rx_level_low,
   input wire logic i_alt_mode,
   // Host contacts driven by the module
   output omcp_pkg::omcp_od_s o_fault_pin,
   output omcp_pkg::omcp_od_s o_los_pin,
   output logic o_module_missing,
   // Module internal control
   output logic o_tx_enable,
   output omcp_pkg::omcp_rate_s o_rate
);

   // ***********************************************
   // Contact resolution
   // ***********************************************
   logic laser_off_in;
   logic rx_pick_in;
   logic tx_pick_in;
   logic laser_off_flt;
   logic rx_pick_flt;
   logic tx_pick_flt;

   // An open laser-off contact floats up to the transmitter supply.
   assign laser_off_in = i_laser_off_driven ? i_laser_off : 1'b1;
   // Open rate picks sink to ground through the weak pull-down.
   assign rx_pick_in = i_pick_driven.rx_rate_pick ? i_pick.rx_rate_pick : omcp_pkg::RATE_LOW;
   assign tx_pick_in = i_pick_driven.tx_rate_pick ? i_pick.tx_rate_pick : omcp_pkg::RATE_LOW;

   omcp_filter #(.CYCLES(STABLE), .RST_VAL(omcp_pkg::RST_LASER_OFF)) u_flt_off (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(laser_off_in),
      .o_level(laser_off_flt)
   );

   omcp_filter #(.CYCLES(STABLE), .RST_VAL(omcp_pkg::RST_RATE)) u_flt_rx (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(rx_pick_in),
      .o_level(rx_pick_flt)
   );

   omcp_filter #(.CYCLES(STABLE), .RST_VAL(omcp_pkg::RST_RATE)) u_flt_tx (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(tx_pick_in),
      .o_level(tx_pick_flt)
   );

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic tx_enable;
      omcp_pkg::omcp_sel_mode_e mode;
      omcp_pkg::omcp_rate_s rate;
   } omcp_state_s;

   omcp_state_s state_reg;
   omcp_state_s state_next;

   always_comb begin
      state_next = state_reg;
      // Laser off wins the moment it is seen; enabling waits for the filtered low.
      if (PASSIVE) begin
         state_next.tx_enable = 1'b1;
      end else if (laser_off_in || laser_off_flt) begin
         state_next.tx_enable = 1'b0;
      end else begin
         state_next.tx_enable = 1'b1;
      end
      state_next.mode = i_alt_mode ? omcp_pkg::OMCP_MODE_ALT : omcp_pkg::OMCP_MODE_RATE;
      unique case (state_next.mode)
         omcp_pkg::OMCP_MODE_ALT: begin
            state_next.rate.rx_high_rate = omcp_pkg::RATE_LOW;
            state_next.rate.tx_high_rate = omcp_pkg::RATE_LOW;
            state_next.rate.alt_select_zero = rx_pick_flt;
            state_next.rate.alt_select_one = tx_pick_flt;
         end
         omcp_pkg::OMCP_MODE_RATE: begin
            state_next.rate.rx_high_rate = (rx_pick_flt == omcp_pkg::RATE_HIGH);
            state_next.rate.tx_high_rate = (tx_pick_flt == omcp_pkg::RATE_HIGH);
            state_next.rate.alt_select_zero = 1'b0;
            state_next.rate.alt_select_one = 1'b0;
         end
         default: begin
            state_next.rate = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= '{tx_enable: 1'b0, mode: omcp_pkg::OMCP_MODE_RATE, rate: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_tx_enable = state_reg.tx_enable;
   assign o_rate = state_reg.rate;

   // ***********************************************
   // Status pins
   // ***********************************************
   // Status pins are open-drain, so the host must pull up and synchronise them.
   omcp_od_pin #(.IMPLEMENTED(FAULT_IMPL)) u_fault (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_assert(i_laser_fault),
      .o_pin(o_fault_pin)
   );

   omcp_od_pin #(.IMPLEMENTED(LOS_IMPL)) u_los (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_assert(i_rx_level_low),
      .o_pin(o_los_pin)
   );

   // An inserted module grounds this contact; the host pull-up makes absence read high.
   assign o_module_missing = 1'b0;

endmodule
`default_nettype wire

// ---- omcp_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module omcp_ctrl_checker #(
   parameter int STABLE = 1,
   parameter bit FAULT_IMPL = 1'b1,
   parameter bit PASSIVE = 1'b0
) (
   // Clock, reset and inputs
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_laser_off,
   input wire logic i_laser_off_driven,
   input wire omcp_pkg::omcp_pick_s i_pick,
   input wire omcp_pkg::omcp_pick_s i_pick_driven,
   input wire logic i_laser_fault,
   input wire logic i_rx_level_low,
   input wire logic i_alt_mode,
   // Outputs
   input wire omcp_pkg::omcp_od_s o_fault_pin,
   input wire omcp_pkg::omcp_od_s o_los_pin,
   input wire logic o_module_missing,
   input wire logic o_tx_enable,
   input wire omcp_pkg::omcp_rate_s o_rate
);
   // The eight-cycle holds below assume STABLE stays at six or less.
   wire logic on_req = i_laser_off_driven && !i_laser_off;
   wire logic [1:0] eff = i_pick & i_pick_driven;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_on_held;
      on_req [*8];
   endsequence
   sequence s_rate_held;
      (!i_alt_mode && $stable(eff)) [*8];
   endsequence
   sequence s_alt_held;
      (i_alt_mode && $stable(eff)) [*8];
   endsequence

   AST_FAULT: assert property (!$past(i_rst) |-> o_fault_pin.oe_n == ($past(i_laser_fault) && FAULT_IMPL))
      else $error("fault pin does not follow the fault level");
   AST_OPEN_DRAIN: assert property (!o_fault_pin.out_bit && !o_los_pin.out_bit)
      else $error("status pin drives a high level");
   AST_LOS: assert property (!$past(i_rst) |-> o_los_pin.oe_n == $past(i_rx_level_low))
      else $error("signal lost pin does not follow the level");
   AST_MISSING: assert property (o_module_missing == 1'b0)
      else $error("module missing contact not grounded");
   AST_OFF: assert property (!PASSIVE && !on_req |=> !o_tx_enable)
      else $error("transmitter on while laser-off requested");
   AST_PASSIVE: assert property (PASSIVE && !$past(i_rst) |-> o_tx_enable)
      else $error("passive variant transmitter not running");
   AST_ON: assert property (s_on_held |-> o_tx_enable)
      else $error("transmitter off while laser-off held low");
   AST_RATE: assert property (s_rate_held |-> o_rate == {eff, 2'b00})
      else $error("rate outputs do not match the picks");
   AST_ALT: assert property (s_alt_held |-> o_rate == {2'b00, eff})
      else $error("alternate selects do not match the picks");
endmodule

bind omcp_ctrl omcp_ctrl_checker #(
   .STABLE(STABLE), .FAULT_IMPL(FAULT_IMPL), .PASSIVE(PASSIVE)
) i_omcp_ctrl_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_laser_off(i_laser_off),
   .i_laser_off_driven(i_laser_off_driven), .i_pick(i_pick), .i_pick_driven(i_pick_driven),
   .i_laser_fault(i_laser_fault), .i_rx_level_low(i_rx_level_low), .i_alt_mode(i_alt_mode),
   .o_fault_pin(o_fault_pin), .o_los_pin(o_los_pin), .o_module_missing(o_module_missing),
   .o_tx_enable(o_tx_enable), .o_rate(o_rate)
);

`default_nettype wire

// ---- omcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module omcp_host_model (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Commands from the bench
   input wire logic i_off_req,
   input wire logic i_off_open,
   input wire omcp_pkg::omcp_pick_s i_pick_req,
   input wire omcp_pkg::omcp_pick_s i_pick_open,
   // Module contacts
   input wire omcp_pkg::omcp_od_s i_fault_pin,
   input wire omcp_pkg::omcp_od_s i_los_pin,
   output logic o_laser_off,
   output logic o_laser_off_driven,
   output omcp_pkg::omcp_pick_s o_pick,
   output omcp_pkg::omcp_pick_s o_pick_driven,
   output logic [1:0] o_seen
);
   // An open contact shows a toggling level, so only the sense input may decide.
   logic toggle_reg = 1'b0;
   logic [1:0] sync1_reg;
   logic [1:0] wire_lvl;

   assign o_laser_off = i_off_open ? toggle_reg : i_off_req;
   assign o_laser_off_driven = !i_off_open;
   assign o_pick = (i_pick_req & ~i_pick_open) | ({2{toggle_reg}} & i_pick_open);
   assign o_pick_driven = ~i_pick_open;
   assign wire_lvl[1] = i_fault_pin.oe_n ? 1'b1 : i_fault_pin.out_bit;
   assign wire_lvl[0] = i_los_pin.oe_n ? 1'b1 : i_los_pin.out_bit;

   always_ff @(posedge i_clk_sys) begin
      toggle_reg <= !toggle_reg;
      sync1_reg <= i_rst ? 2'h3 : wire_lvl;
      o_seen <= i_rst ? 2'h3 : sync1_reg;
   end
endmodule

`default_nettype wire

// ---- tb_optical_module_control_pins.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb_optical_module_control_pins;
   logic i_clk_sys, i_rst, off_req, off_open, fault, lvl, alt, lo_off, lo_drv, tx_en, missing;
   omcp_pkg::omcp_pick_s pick_req, pick_open, pk, pk_drv;
   omcp_pkg::omcp_od_s fpin, lpin;
   omcp_pkg::omcp_rate_s rate;
   logic [1:0] seen;
   int fail_count = 0;
   int num_checks = 0;
   logic [31:0] x = 32'h4a02;
   logic tx_en_p;
   omcp_pkg::omcp_od_s fpin_p;
   omcp_pkg::omcp_rate_s rate_p;
   // Four times the cycles that reset, the glitch test and the random test take.
   localparam int WATCHDOG_CYCLES = 4 * (6 + 6 + 40 * 8);

   function automatic logic [31:0] xorshift(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      xorshift = r ^ (r << 5);
   endfunction

   omcp_ctrl #(.STABLE(3)) i_omcp_ctrl (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_laser_off(lo_off), .i_laser_off_driven(lo_drv), .i_pick(pk), .i_pick_driven(pk_drv),
      .i_laser_fault(fault), .i_rx_level_low(lvl), .i_alt_mode(alt), .o_fault_pin(fpin),
      .o_los_pin(lpin), .o_module_missing(missing), .o_tx_enable(tx_en), .o_rate(rate));
   omcp_host_model i_omcp_host_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_off_req(off_req), .i_off_open(off_open), .i_pick_req(pick_req),
      .i_pick_open(pick_open), .i_fault_pin(fpin), .i_los_pin(lpin), .o_laser_off(lo_off),
      .o_laser_off_driven(lo_drv), .o_pick(pk), .o_pick_driven(pk_drv), .o_seen(seen));
   // A passive variant without fault detection sees the same contacts as the active one.
   omcp_ctrl #(.FAULT_IMPL(1'b0), .PASSIVE(1'b1), .STABLE(3)) i_omcp_ctrl_passive (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_laser_off(lo_off), .i_laser_off_driven(lo_drv),
      .i_pick(pk), .i_pick_driven(pk_drv), .i_laser_fault(fault), .i_rx_level_low(lvl),
      .i_alt_mode(alt), .o_fault_pin(fpin_p), .o_los_pin(), .o_module_missing(),
      .o_tx_enable(tx_en_p), .o_rate(rate_p));

   // ***********************************************
   // Helpers
   // ***********************************************
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = !i_clk_sys;
   end

   initial begin
      repeat (WATCHDOG_CYCLES) @(posedge i_clk_sys);
      fail_count++;
      $display("[ERR] watchdog expected %s seen %s", "done", "timeout");
      complete_run();
   end

   // ***********************************************
   // Tests
   // ***********************************************
   initial begin
      int ex_tx, ex_rx, ex_txr;
      logic [3:0] ex_rate;
      i_rst = 1'b1;
      {off_req, off_open, fault, lvl, alt} = 5'h10;
      pick_req = 2'h0;
      pick_open = 2'h0;
      step(4);
      `CHK("rst_tx", 1'b0, tx_en);
      `CHK("rst_rate", 4'h0, rate);
      i_rst = 1'b0;
      $display("reset test done");
      // A short low pulse on laser-off must not switch the transmitter on.
      off_req = 1'b0;
      step(2);
      off_req = 1'b1;
      repeat (6) begin
         step(1);
         `CHK("glitch_tx", 1'b0, tx_en);
         `CHK("passive_glitch_tx", 1'b1, tx_en_p);
      end
      $display("glitch test done");
      repeat (40) begin
         x = xorshift(x);
         {alt, lvl, fault, pick_open, pick_req, off_open, off_req} = x[8:0];
         step(8);
         ex_tx = !off_open && !off_req;
         ex_rx = pick_req.rx_rate_pick && !pick_open.rx_rate_pick;
         ex_txr = pick_req.tx_rate_pick && !pick_open.tx_rate_pick;
         ex_rate = alt ? {2'b00, ex_rx[0], ex_txr[0]} : {ex_rx[0], ex_txr[0], 2'b00};
         `CHK("tx_enable", ex_tx[0], tx_en);
         `CHK("rate", ex_rate, rate);
         `CHK("passive_tx", 1'b1, tx_en_p);
         `CHK("nofault_pin", 1'b0, fpin_p.oe_n);
         `CHK("passive_rate", ex_rate, rate_p);
         `CHK("fault_seen", fault, seen[1]);
         `CHK("los_seen", lvl, seen[0]);
         `CHK("missing", 1'b0, missing);
      end
      $display("random test done");
      complete_run();
   end
endmodule

`default_nettype wire
